// file: src/cts_clkdiv.v
// divided function clock tick generator
`timescale 1ns/1ps
module cts_clkdiv
(
   input  wire       clk,
   input  wire       rst_n,
   input  wire [3:0] div,
   output wire       tick
);
   reg [3:0] cnt_reg;   // cycles since last tick
   reg [3:0] cnt_next;

   // one tick every div+1 system cycles
   assign tick = (cnt_reg >= div); // [RULE18]

   // wrap on tick; >= keeps a shrinking divider from stalling
   always @*
   begin
      if (tick)
         cnt_next = 4'h0;
      else
         cnt_next = cnt_reg + 4'h1;
   end

   // counter flop
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_reg <= 4'h0;
      else
         cnt_reg <= cnt_next;
   end
endmodule

// file: src/cts_defs.vh
// constants for the capacitive touch status and timing block
`ifndef CTS_DEFS_VH
`define CTS_DEFS_VH
// register byte offsets
`define CTS_OFS_CTRL      12'h000
`define CTS_OFS_STATUS    12'h004
`define CTS_OFS_TIMING    12'h008
`define CTS_OFS_RESULT    12'h00C
// status field positions
`define CTS_ST_TOUCH      0
`define CTS_ST_RELEASE    1
`define CTS_ST_ROUND      2
`define CTS_ST_EXPIRY     3
`define CTS_ST_OVERWR     4
`define CTS_ST_BUSY       8
`define CTS_ST_SENSE_PIN_COUNT_MINUS_ONE_LO    16
// timing field positions
`define CTS_TM_THR_LO     0
`define CTS_TM_EXP_LO     12
`define CTS_TM_GAP_LO     16
`define CTS_TM_SETTLE_LO  24
`define CTS_TM_DWELL_LO   26
`define CTS_TM_POL        31
// control field positions
`define CTS_CT_MODE_LO    0
`define CTS_CT_DIV_LO     8
// result field positions
`define CTS_RS_TOUCH      16
`define CTS_RS_EXPIRY     17
// scan modes
`define CTS_MODE_OFF      2'h0
`define CTS_MODE_SINGLE   2'h1
`define CTS_MODE_CONT     2'h2
// reset values
`define CTS_RST_CTRL      32'h0000_0000
`define CTS_RST_TIMING    32'h0000_0000
`define CTS_RST_FLAGS     5'h00
// settle delay per code, in divided clocks
`define CTS_SETTLE_0      4'h0
`define CTS_SETTLE_1      4'h3
`define CTS_SETTLE_2      4'h5
`define CTS_SETTLE_3      4'h9
// divided clocks per unit of round interval
`define CTS_ROUND_GAP_UNIT 4096
`endif

// file: src/cts_top.v
// capacitive touch scan sequencer with status and timing registers
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cts_defs.vh"
// Notes on behaviour
// [RULE1] flags sticky, write one clears them
// [RULE2] touch classification sets bit 0
// [RULE3] no-touch classification sets bit 1
// [RULE4] round or single-shot end sets bit 2
// [RULE5] expiry before trigger sets bit 3
// [RULE6] unread touch result overwritten sets bit 4
// [RULE7] unread no-touch result overwritten silently
// [RULE8] busy bit 8 high during poll
// [RULE9] bits 19:16 give pin count minus one
// [RULE10] software changes timing only when idle; here timing writes take effect at once, even mid-scan
// [RULE11] bits 11:0 are the touch threshold
// [RULE12] expiry count is two to exponent
// [RULE13] wait 4096 times interval between rounds
// [RULE14] settle wait 0,3,5,9 before sampling
// [RULE15] dwell 1,2,4,8 in step zero
// [RULE16] polarity clear: above threshold is touch
// [RULE17] polarity set: at or below is touch
// [RULE18] divided clock is function clock over divider+1
// [RULE19] result touch bit marks touch trigger
// [RULE20] counter steps once per divided clock
module cts_top
#(
   parameter        SENSE_PINS     = 1,
   parameter [20:0] ROUND_GAP_UNIT = `CTS_ROUND_GAP_UNIT
)
(
   input  wire                  CLK_SYS,
   input  wire                  RESET_N,
   input  wire                  HSEL,
   input  wire [11:0]           HADDR,
   input  wire [1:0]            HTRANS,
   input  wire                  HWRITE,
   input  wire [2:0]            HSIZE,
   input  wire [31:0]           HWDATA,
   input  wire                  HREADY,
   output wire [31:0]           HRDATA,
   output wire                  HREADYOUT,
   output wire                  HRESP,
   input  wire                  SENSE_RETURN,
   output wire [SENSE_PINS-1:0] SENSE_DRIVE_OUT,
   output wire [SENSE_PINS-1:0] SENSE_DRIVE_OE
);
   // sequencer states
   localparam [2:0] ST_IDLE   = 3'd0;
   localparam [2:0] ST_DWELL  = 3'd1;
   localparam [2:0] ST_SETTLE = 3'd2;
   localparam [2:0] ST_COUNT  = 3'd3;
   localparam [2:0] ST_GAP    = 3'd4;
   localparam [31:0] PIN_MAX  = SENSE_PINS - 1; // full width before the cut to four bits
   localparam [3:0] SENSE_PIN_COUNT_MINUS_ONE      = PIN_MAX[3:0];
   localparam [3:0] LAST_X    = PIN_MAX[3:0];

   // bus side
   reg         wr_pend_reg;      // write data phase pending
   reg  [11:0] wr_addr_reg;      // address of pending write
   reg  [31:0] rdata_reg;        // read data for data phase
   reg  [31:0] rdata_next;
   wire        acc;              // accepted address phase
   wire        rd_acc;
   wire        wr_ctrl;
   wire        wr_status;
   wire        wr_timing;

   // software visible state
   reg  [1:0]  mode_reg;         // scan_mode_select
   reg  [3:0]  div_reg;          // function_clock_divider
   reg  [31:0] timing_reg;       // scan_timing_threshold
   reg  [4:0]  flags_reg;        // sticky event flags
   reg  [4:0]  flags_set;
   reg  [11:0] res_count_reg;    // last measured count
   reg  [3:0]  res_x_reg;        // pin of last result
   reg         res_touch_reg;    // result_touch_bit
   reg         res_expiry_reg;
   reg         res_unread_reg;   // result not yet read

   // timing fields
   wire [11:0] touch_threshold;
   wire [3:0]  expiry_exponent;
   wire [7:0]  round_interval;
   wire [1:0]  sample_settle_delay;
   wire [1:0]  reset_state_dwell;
   wire        touch_polarity;

   // sequencer
   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [3:0]  x_reg;            // pin under measurement
   reg  [3:0]  x_next;
   reg  [3:0]  wait_reg;         // dwell and settle countdown
   reg  [3:0]  wait_next;
   reg  [12:0] cnt_reg;          // measurement counter
   reg  [12:0] cnt_next;
   reg  [20:0] gap_reg;          // inter-round countdown
   reg  [20:0] gap_next;
   reg         rec;              // store a result this cycle
   reg  [12:0] rec_count;
   reg         rec_touch;
   reg         rec_expiry;
   reg         round_end;
   wire        tick;
   wire [13:0] exp_count;
   wire [12:0] cnt_inc;
   wire        above;
   wire        is_touch;
   wire        busy;
   wire [3:0]  settle_load;
   wire [3:0]  dwell_load;
   wire [20:0] gap_load;

   // return pin synchroniser
   reg         sync1_reg;        // metastability stage only
   reg         sync2_reg;
   reg         sync3_reg;
   reg         sense_reg;        // filtered return level

   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = rdata_reg;

   assign touch_threshold     = timing_reg[`CTS_TM_THR_LO +: 12]; // [RULE11]
   assign expiry_exponent     = timing_reg[`CTS_TM_EXP_LO +: 4];
   assign round_interval      = timing_reg[`CTS_TM_GAP_LO +: 8];
   assign sample_settle_delay = timing_reg[`CTS_TM_SETTLE_LO +: 2];
   assign reset_state_dwell   = timing_reg[`CTS_TM_DWELL_LO +: 2];
   assign touch_polarity      = timing_reg[`CTS_TM_POL];

   // zero wait state slave: every accepted phase completes next cycle
   assign acc       = HSEL & HTRANS[1] & HREADY;
   assign rd_acc    = acc & ~HWRITE;
   assign wr_ctrl   = wr_pend_reg & (wr_addr_reg == `CTS_OFS_CTRL);
   assign wr_status = wr_pend_reg & (wr_addr_reg == `CTS_OFS_STATUS);
   assign wr_timing = wr_pend_reg & (wr_addr_reg == `CTS_OFS_TIMING);

   // divided function clock
   cts_clkdiv u_div
   (
      .clk   (CLK_SYS),
      .rst_n (RESET_N),
      .div   (div_reg),
      .tick  (tick)
   );

   // exponent above 12 is illegal; the result is then undefined
   assign exp_count = 14'h0001 << expiry_exponent; // [RULE12]
   assign cnt_inc   = cnt_reg + 13'h0001;
   assign above     = (cnt_reg > {1'b0, touch_threshold});
   // polarity picks which side of the threshold is a touch
   assign is_touch  = touch_polarity ? ~above : above; // [RULE16] [RULE17]
   assign busy      = (state_reg != ST_IDLE) && (state_reg != ST_GAP); // [RULE8]

   assign settle_load = (sample_settle_delay == 2'd0) ? `CTS_SETTLE_0 :
                        (sample_settle_delay == 2'd1) ? `CTS_SETTLE_1 :
                        (sample_settle_delay == 2'd2) ? `CTS_SETTLE_2 :
                        `CTS_SETTLE_3; // [RULE14]
   // dwell counts down to zero, so load one less than 1,2,4,8
   assign dwell_load  = (4'h1 << reset_state_dwell) - 4'h1; // [RULE15]
   assign gap_load    = {13'h0000, round_interval} * ROUND_GAP_UNIT; // [RULE13]

   // read mux, sampled in the address phase
   always @*
   begin
      rdata_next = 32'h0000_0000;
      case (HADDR)
         `CTS_OFS_CTRL:
            rdata_next = {20'h0_0000, div_reg, 6'h00, mode_reg};
         `CTS_OFS_STATUS:
            rdata_next = {12'h000, SENSE_PIN_COUNT_MINUS_ONE, 7'h00, busy, 3'h0, flags_reg}; // [RULE9]
         `CTS_OFS_TIMING:
            rdata_next = timing_reg;
         `CTS_OFS_RESULT:
            rdata_next = {14'h0000, res_expiry_reg, res_touch_reg,
                          res_x_reg, res_count_reg};
         default:
            rdata_next = 32'h0000_0000;  // unmapped reads as zero
      endcase
   end

   // bus phase flops
   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
         rdata_reg   <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_reg <= acc & HWRITE;
         if (acc)
            wr_addr_reg <= HADDR;
         if (rd_acc)
            rdata_reg <= rdata_next;
      end
   end

   // sequencer next state
   always @*
   begin
      state_next = state_reg;
      x_next     = x_reg;
      wait_next  = wait_reg;
      cnt_next   = cnt_reg;
      gap_next   = gap_reg;
      rec        = 1'b0;
      rec_count  = cnt_reg;
      rec_touch  = 1'b0;
      rec_expiry = 1'b0;
      round_end  = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            if (mode_reg == `CTS_MODE_SINGLE || mode_reg == `CTS_MODE_CONT)
            begin
               state_next = ST_DWELL;
               x_next     = 4'h0;
               wait_next  = dwell_load;
            end
         end
         ST_DWELL:
         begin
            if (tick)
            begin
               if (wait_reg == 4'h0)
               begin
                  state_next = ST_SETTLE;
                  wait_next  = settle_load;
               end
               else
                  wait_next = wait_reg - 4'h1; // [RULE15]
            end
         end
         ST_SETTLE:
         begin
            // the return pin is ignored until the settle time is over
            if (tick)
            begin
               if (wait_reg == 4'h0)
               begin
                  state_next = ST_COUNT;
                  cnt_next   = 13'h0000;
               end
               else
                  wait_next = wait_reg - 4'h1; // [RULE14]
            end
         end
         ST_COUNT:
         begin
            if (tick)
            begin
               if (sense_reg)
               begin
                  rec       = 1'b1;
                  rec_touch = is_touch; // [RULE19]
               end
               else if ({1'b0, cnt_inc} == exp_count)
               begin
                  rec        = 1'b1; // [RULE5]
                  rec_expiry = 1'b1;
                  rec_count  = cnt_inc;
               end
               else
                  cnt_next = cnt_inc; // [RULE20]
               if (rec)
               begin
                  if (x_reg == LAST_X)
                  begin
                     round_end = 1'b1;
                     x_next    = 4'h0;
                     if (mode_reg == `CTS_MODE_CONT)
                     begin
                        state_next = ST_GAP;
                        gap_next   = gap_load;
                     end
                     else
                        state_next = ST_IDLE;
                  end
                  else
                  begin
                     state_next = ST_DWELL;
                     x_next     = x_reg + 4'h1;
                     wait_next  = dwell_load;
                  end
               end
            end
         end
         ST_GAP:
         begin
            if (tick)
            begin
               if (gap_reg == 21'h00_0000)
               begin
                  state_next = ST_DWELL;
                  wait_next  = dwell_load;
               end
               else
                  gap_next = gap_reg - 21'h00_0001; // [RULE13]
            end
         end
         default:
            state_next = ST_IDLE;
      endcase
      // scan mode cleared by software stops the scan at once
      if (mode_reg == `CTS_MODE_OFF)
         state_next = ST_IDLE;
   end

   // event set terms
   always @*
   begin
      flags_set = 5'h00;
      flags_set[`CTS_ST_TOUCH]   = rec & ~rec_expiry & rec_touch; // [RULE2]
      flags_set[`CTS_ST_RELEASE] = rec & ~rec_expiry & ~rec_touch; // [RULE3]
      flags_set[`CTS_ST_ROUND]   = round_end; // [RULE4]
      flags_set[`CTS_ST_EXPIRY]  = rec & rec_expiry; // [RULE5]
      // a pending no-touch result is simply replaced
      flags_set[`CTS_ST_OVERWR]  = rec & res_unread_reg & res_touch_reg; // [RULE6] [RULE7]
   end

   // sequencer flops
   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state_reg <= ST_IDLE;
         x_reg     <= 4'h0;
         wait_reg  <= 4'h0;
         cnt_reg   <= 13'h0000;
         gap_reg   <= 21'h00_0000;
      end
      else
      begin
         state_reg <= state_next;
         x_reg     <= x_next;
         wait_reg  <= wait_next;
         cnt_reg   <= cnt_next;
         gap_reg   <= gap_next;
      end
   end

   // control and timing registers
   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         mode_reg   <= `CTS_MODE_OFF;   // scanning off out of reset
         div_reg    <= 4'h0;
         timing_reg <= `CTS_RST_TIMING;
      end
      else
      begin
         // single shot returns to off when its round ends
         if (round_end && mode_reg == `CTS_MODE_SINGLE)
            mode_reg <= `CTS_MODE_OFF;
         // a software write in the same cycle wins, being newer
         if (wr_ctrl)
         begin
            mode_reg <= HWDATA[`CTS_CT_MODE_LO +: 2];
            div_reg  <= HWDATA[`CTS_CT_DIV_LO +: 4];
         end
         // no interlock: writes during a scan take effect at once
         if (wr_timing)
            timing_reg <= HWDATA; // [RULE10]
      end
   end

   // sticky flags: a set in the clearing cycle survives
   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         flags_reg <= `CTS_RST_FLAGS;
      else if (wr_status)
         flags_reg <= (flags_reg & ~HWDATA[4:0]) | flags_set; // [RULE1]
      else
         flags_reg <= flags_reg | flags_set; // [RULE1]
   end

   // result register
   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         res_count_reg  <= 12'h000;
         res_x_reg      <= 4'h0;
         res_touch_reg  <= 1'b0;
         res_expiry_reg <= 1'b0;
         res_unread_reg <= 1'b0;
      end
      else if (rec)
      begin
         // a count of 4096 saturates in the 12-bit field
         res_count_reg  <= rec_count[12] ? 12'hFFF : rec_count[11:0];
         res_x_reg      <= x_reg;
         res_touch_reg  <= rec_touch; // [RULE19]
         res_expiry_reg <= rec_expiry;
         res_unread_reg <= 1'b1;
      end
      else if (rd_acc && HADDR == `CTS_OFS_RESULT)
         res_unread_reg <= 1'b0;
   end

   // three stage synchroniser; level taken when stages two and three agree
   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
         sense_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= SENSE_RETURN;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         if (sync2_reg == sync3_reg)
            sense_reg <= sync3_reg;
      end
   end

   // pad drive per pin: low in dwell, high while settling and counting
   genvar g;
   generate
      for (g = 0; g < SENSE_PINS; g = g + 1)
      begin : g_pad
         reg out_reg;
         reg oe_reg;
         always @(posedge CLK_SYS or negedge RESET_N)
         begin
            if (!RESET_N)
            begin
               out_reg <= 1'b0;
               oe_reg  <= 1'b0;
            end
            else
            begin
               oe_reg  <= (x_next == g) && (state_next == ST_DWELL ||
                          state_next == ST_SETTLE || state_next == ST_COUNT);
               out_reg <= (x_next == g) && (state_next == ST_SETTLE ||
                          state_next == ST_COUNT);
            end
         end
         assign SENSE_DRIVE_OUT[g] = out_reg;
         assign SENSE_DRIVE_OE[g]  = oe_reg;
      end
   endgenerate
endmodule

// file: tb/cap_touch_status_and_timing_tb.sv
// self-checking bench for the touch status and timing block
`timescale 1ns/1ps
module cap_touch_status_and_timing_tb;
   logic        clk_sys, reset_n, hsel, hwrite, busy_seen;
   logic [11:0] haddr, c0;
   logic [1:0]  htrans;
   logic [31:0] hwdata, st, rs, ctl;
   logic [15:0] dly;
   logic [11:0] cnt [4];
   logic [31:0] sdl [4] = '{32'h0000_0000, 32'h0000_0003, 32'h0000_0005, 32'h0000_0009};
   wire  [31:0] hrdata;
   wire         hready, hresp, ret;
   wire  [0:0]  d_out, d_oe;
   int          fail_count, check_count, i, n, n0, rounds, dw_cnt, last_dw, gap_cnt, last_gap;
   // gap unit shortened so continuous rounds stay quick
   cts_top #(.SENSE_PINS(1), .ROUND_GAP_UNIT(21'h00_0004)) cts_top_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n),
      .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .SENSE_RETURN(ret),
      .SENSE_DRIVE_OUT(d_out), .SENSE_DRIVE_OE(d_oe));
   cts_sensor_model cts_sensor_model_inst (.clk(clk_sys), .drive_out(d_out[0]), .drive_oe(d_oe[0]),
      .dly(dly), .ret(ret));
   // dwell and inter-round gap lengths measured on the pads
   always @(posedge clk_sys)
   begin
      dw_cnt <= (d_oe[0] && !d_out[0]) ? dw_cnt + 1 : 0;
      if (d_out[0] && dw_cnt != 0)
         last_dw <= dw_cnt;
      gap_cnt <= d_oe[0] ? 0 : gap_cnt + 1;
      if (d_oe[0] && gap_cnt != 0)
      begin
         last_gap <= gap_cnt;
         rounds <= rounds + 1;
      end
   end
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic tmo;
      fail_count++;
      results();
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // wait for an edge where hready is sampled high
   task automatic rdy;
      int k;
      @(posedge clk_sys);
      for (k = 0; hready !== 1'b1 && k < 20; k++)
         @(posedge clk_sys);
      if (k >= 20)
         tmo();
   endtask
   // one single word transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      q = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0000_0000, q);
   endtask
   // clear flags, run one single shot, poll until the round ends
   task automatic scan(input logic get, output logic [31:0] s, output logic [31:0] r);
      int k;
      s = 32'h0000_0000;
      wr(12'h004, 32'h0000_001F);
      wr(12'h000, ctl | 32'h0000_0001);
      for (k = 0; s[2] !== 1'b1 && k < 400; k++)
      begin
         rd(12'h004, s);
         if (s[8] === 1'b1)
            busy_seen = 1'b1;
      end
      if (k >= 400)
         tmo();
      if (get)
         rd(12'h00C, r);
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      reset_n = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwdata = 32'h0000_0000;
      dly = 16'h0028;
      ctl = 32'h0000_0000;
      busy_seen = 1'b0;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(12'h004, st);
      chk("status reset", st, 32'h0000_0000);
      rd(12'h008, st);
      chk("timing reset", st, 32'h0000_0000);
      rd(12'h100, st);
      chk("unmapped", st, 32'h0000_0000);
      wr(12'h008, 32'h8F12_3456);
      rd(12'h008, st);
      chk("timing rw", st, 32'h8F12_3456);
      // trigger count shrinks by exactly the settle wait
      for (i = 0; i < 4; i++)
      begin
         wr(12'h008, 32'h0000_C000 | (i << 24));
         scan(1'b1, st, rs);
         cnt[i] = rs[11:0];
         chk("settle", {20'h0_0000, cnt[0] - cnt[i]}, sdl[i]);
      end
      c0 = cnt[0];
      // threshold boundary under both polarities
      for (i = 0; i < 4; i++)
      begin
         wr(12'h008, {i[1], 15'h0000, 4'hC, c0 - 12'h001 + 12'(i[0])});
         scan(1'b1, st, rs);
         n = (i[0] == i[1]) ? 5 : 6;
         chk("class", {27'h000_0000, st[4:0]}, n);
         chk("touch bit", {31'h0000_0000, rs[16]}, {31'h0000_0000, i[0] == i[1]});
      end
      wr(12'h004, 32'h0000_0001);
      rd(12'h004, st);
      chk("clear one", st, 32'h0000_0004);
      wr(12'h004, 32'h0000_0000);
      rd(12'h004, st);
      chk("write zero", st, 32'h0000_0004);
      // unread touch result overwritten, then unread no-touch result
      wr(12'h008, {20'h0_000C, c0 - 12'h001});
      scan(1'b0, st, rs);
      scan(1'b0, st, rs);
      chk("overwrite touch", {31'h0000_0000, st[4]}, 32'h0000_0001);
      rd(12'h00C, rs);
      wr(12'h008, {20'h0_000C, c0});
      scan(1'b0, st, rs);
      scan(1'b0, st, rs);
      chk("overwrite quiet", {31'h0000_0000, st[4]}, 32'h0000_0000);
      rd(12'h00C, rs);
      // no trigger: expiry at two to the third
      dly = 16'hFFFF;
      wr(12'h008, 32'h0000_3000);
      scan(1'b1, st, rs);
      chk("expiry flags", {27'h000_0000, st[4:0]}, 32'h0000_000C);
      chk("expiry result", {14'h0000, rs[17:0]}, 32'h0002_0008);
      dly = 16'h0028;
      // dwell per code, last one with the divider at two
      for (i = 0; i < 5; i++)
      begin
         if (i == 4)
            ctl = 32'h0000_0200;
         wr(12'h008, 32'h0000_C000 | (((i < 4) ? i : 3) << 26));
         scan(1'b1, st, rs);
         // eight divided clocks of three; the first may be up to two cycles short
         n = (i < 4 || last_dw < 22) ? last_dw : 24;
         chk("dwell", n, (i < 4) ? (1 << i) : 24);
      end
      ctl = 32'h0000_0000;
      // continuous rounds with an interval of two units
      wr(12'h008, 32'h0002_C000);
      wr(12'h004, 32'h0000_001F);
      wr(12'h000, 32'h0000_0002);
      n0 = rounds;
      for (n = 0; rounds < n0 + 2 && n < 2000; n++)
         @(posedge clk_sys);
      if (n >= 2000)
         tmo();
      chk("gap", (last_gap >= 8 && last_gap <= 14), 32'h0000_0001);
      rd(12'h004, st);
      chk("round flag", {31'h0000_0000, st[2]}, 32'h0000_0001);
      wr(12'h000, 32'h0000_0000);
      rd(12'h004, st);
      rd(12'h004, st);
      chk("idle busy", {31'h0000_0000, st[8]}, 32'h0000_0000);
      chk("busy seen", {31'h0000_0000, busy_seen}, 32'h0000_0001);
      // the spare mode code must never start a scan
      wr(12'h000, 32'h0000_0003);
      rd(12'h004, st);
      chk("mode three idle", {31'h0000_0000, st[8]}, 32'h0000_0000);
      results();
   end
endmodule

// file: tb/cts_assertions.sv
// port checker for the touch status and timing block
`timescale 1ns/1ps
module cts_assertions
#(
   parameter SENSE_PINS = 1
)
(
   input wire logic                  CLK_SYS,
   input wire logic                  RESET_N,
   input wire logic                  HSEL,
   input wire logic [11:0]           HADDR,
   input wire logic [1:0]            HTRANS,
   input wire logic                  HWRITE,
   input wire logic [2:0]            HSIZE,
   input wire logic [31:0]           HWDATA,
   input wire logic                  HREADY,
   input wire logic [31:0]           HRDATA,
   input wire logic                  HREADYOUT,
   input wire logic                  HRESP,
   input wire logic                  SENSE_RETURN,
   input wire logic [SENSE_PINS-1:0] SENSE_DRIVE_OUT,
   input wire logic [SENSE_PINS-1:0] SENSE_DRIVE_OE
);
   wire         rd_req = HSEL && HTRANS[1] && HREADY && !HWRITE; // read taken this edge
   logic [16:0] hi_cnt;                                           // cycles the pad is held high
   // long measurements must still end, so count the high time
   always @(posedge CLK_SYS or negedge RESET_N)
      if (!RESET_N)
         hi_cnt <= 17'h0_0000;
      else
         hi_cnt <= SENSE_DRIVE_OUT[0] ? hi_cnt + 17'h0_0001 : 17'h0_0000;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);
   property p_okay;
      HRESP == 1'b0 && HREADYOUT == 1'b1;
   endproperty
   a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");
   property p_unmapped;
      rd_req && HADDR == 12'h100 |=> HRDATA == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_pins;
      rd_req && HADDR == 12'h004 |=> HRDATA[19:16] == 4'(SENSE_PINS - 1) && HRDATA[15:9] == 7'h00;
   endproperty
   a_pins: assert property (p_pins) else $error("status pin count or reserved bits wrong");
   property p_busy;
      (rd_req && HADDR == 12'h004 && SENSE_DRIVE_OE[0]) ##1 SENSE_DRIVE_OE[0] |-> HRDATA[8];
   endproperty
   a_busy: assert property (p_busy) else $error("busy low while pad active");
   property p_out_oe;
      SENSE_DRIVE_OUT[0] |-> SENSE_DRIVE_OE[0];
   endproperty
   a_out_oe: assert property (p_out_oe) else $error("pad high without enable");
   property p_dwell_first;
      $rose(SENSE_DRIVE_OE[0]) |-> !SENSE_DRIVE_OUT[0];
   endproperty
   a_dwell_first: assert property (p_dwell_first) else $error("measurement skipped low dwell");
   property p_settle_after;
      $rose(SENSE_DRIVE_OUT[0]) |-> $past(SENSE_DRIVE_OE[0]);
   endproperty
   a_settle_after: assert property (p_settle_after) else $error("pad raised without dwell");
   property p_bounded;
      hi_cnt < 17'h1_1000;
   endproperty
   a_bounded: assert property (p_bounded) else $error("measurement never expired");
   property p_trigger_ends;
      $rose(SENSE_RETURN) |-> ##[1:70] !SENSE_DRIVE_OUT[0];
   endproperty
   a_trigger_ends: assert property (p_trigger_ends) else $error("count not stopped by trigger");
endmodule
bind cts_top cts_assertions #(.SENSE_PINS(SENSE_PINS)) cts_assertions_inst (.CLK_SYS, .RESET_N, .HSEL, .HADDR,
   .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .SENSE_RETURN, .SENSE_DRIVE_OUT,
   .SENSE_DRIVE_OE);

// file: tb/cts_sensor_model.sv
// pad and comparator model on the far side of the scan block
`timescale 1ns/1ps
module cts_sensor_model
(
   input  wire logic        clk,
   input  wire logic        drive_out,
   input  wire logic        drive_oe,
   input  wire logic [15:0] dly,
   output logic             ret
);
   int cnt; // clocks since the pad was driven high
   // a pad held low is discharged, so the charge time restarts
   always @(posedge clk)
      cnt <= (drive_out && drive_oe) ? cnt + 1 : 0;
   // comparator trips once charged; a huge dly never trips
   assign ret = drive_out && drive_oe && (cnt >= dly);
endmodule
